// ==== logic/lbs_pkg.sv ====
// Shared constants for the legacy link byte shifter: register offsets,
// control and status bit positions, ones-run and bit-count limits and reset values.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lbs_pkg;
	// Register offsets on the parallel control port.
	localparam logic [7:0] ADDR_RX_BYTE = 8'h28;
	localparam logic [7:0] ADDR_MATCH_ONE = 8'h29;
	localparam logic [7:0] ADDR_MATCH_TWO = 8'h2a;
	localparam logic [7:0] ADDR_TX_BYTE = 8'h7e;

	// Bit positions in the second status and second interrupt mask registers.
	localparam int SR_MATCH = 2;
	localparam int SR_TX_EMPTY = 3;
	localparam int SR_RX_FULL = 4;

	// Bit positions in the second common control register.
	localparam int CC_DESTUFF_EN = 0;
	localparam int CC_STUFF_EN = 4;
	localparam int CC_MF_LOAD = 5;

	// Bit position in the first transmit control register.
	localparam int TC_FS_SOURCE = 2;

	// Run of ones after which a zero is stuffed or destuffed, the ones-count cap and the last bit index.
	localparam logic [2:0] ONES_RUN = 3'h5;
	localparam logic [2:0] ONES_CAP = 3'h7;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Reset values.
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : lbs_pkg

`default_nettype wire

// ==== logic/lbs_shifter.sv ====
// Legacy link byte shifter: receive byte assembler with zero destuffing and
// match compare, transmit byte serialiser with zero stuffing.
// Assumes the register port and all framer strobes are already synchronous
// to core_clk; the control and mask registers live in the common register
// block and arrive here as plain inputs.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Link or Fs bits shift one at a time into an 8-bit receive register.
// - A completed receive byte sets the receive-full status bit 4.
// - Receive-full pulls the interrupt low only when mask bit 4 is set.
// - Completed byte equal to either match value sets status bit 2, masked by bit 2.
// - First received bit of each byte lands in the least significant position.
// - With destuff enabled, a zero right after exactly five ones is deleted.
// - A zero after six or more ones is kept, passing flags and aborts.
// - Host-written transmit byte is sent LSB first into link or Fs positions.
// - After all 8 transmit bits leave, transmit-empty status bit 3 is set.
// - Transmit-empty pulls the interrupt low only when mask bit 3 is set.
// - Without a new write before the next byte start, the held byte is sent again.
// - With stuff enabled, a zero is inserted after every five consecutive ones.
// - Only one transmit source; this path is silent when the other owns it.
// - Fs source bit cleared selects this transmit byte as Fs source.
// - Multiframe-load bit set makes new transmit bytes load only at multiframe start.
module lbs_shifter
	import lbs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] second_common_control_register,
	input wire logic [7:0] second_interrupt_mask_register,
	input wire logic [7:0] first_transmit_control_register,
	input wire logic [7:0] status_clear,
	output logic [7:0] second_status_register,
	output logic int_n,
	input wire logic esf_mode,
	input wire logic hdlc_tx_select,
	input wire logic rx_link_valid,
	input wire logic rx_link_bit,
	input wire logic tx_link_req,
	input wire logic tx_multiframe,
	output logic tx_link_valid,
	output logic tx_link_bit
);
	import lbs_pkg::*;

	typedef struct packed {
		logic [7:0] rx_shift;
		logic [2:0] rx_count;
		logic [2:0] rx_ones;
		logic [7:0] rx_byte;
		logic [7:0] match_one;
		logic [7:0] match_two;
		logic [7:0] tx_hold;
		logic [7:0] tx_shift;
		logic [2:0] tx_count;
		logic [2:0] tx_ones;
		logic tx_valid;
		logic tx_bit;
		logic [7:0] status;
		logic int_n;
		logic [7:0] rdata;
	} lbs_state_s;

	lbs_state_s st;
	lbs_state_s next_st;

	logic rx_drop;
	logic rx_take;
	logic rx_done;
	logic [7:0] rx_new_shift;
	logic legacy_src;
	logic tx_stuff;
	logic tx_take;
	logic tx_load_ok;
	logic [7:0] tx_byte_eff;
	logic [7:0] set_bits;

	// Ones-run update: saturate so long runs stay recognisable as six or more.
	function automatic logic [2:0] ones_next(input logic [2:0] ones, input logic bit_in);
		ones_next = bit_in ? ((ones == ONES_CAP) ? ONES_CAP : ones + 3'h1) : 3'h0;
	endfunction

	// Next-state logic for both directions and the register port.
	always_comb
	begin
		next_st = st;
		set_bits = STATUS_RESET;

		// Receive: only the zero after exactly five ones is removed.
		rx_drop = rx_link_valid && second_common_control_register[CC_DESTUFF_EN]
			&& (st.rx_ones == ONES_RUN) && !rx_link_bit;
		rx_take = rx_link_valid && !rx_drop;
		rx_done = rx_take && (st.rx_count == LAST_BIT);
		rx_new_shift = {rx_link_bit, st.rx_shift[7:1]};
		if (rx_drop)
		begin
			next_st.rx_ones = 3'h0;
		end
		if (rx_take)
		begin
			next_st.rx_shift = rx_new_shift;
			next_st.rx_count = st.rx_count + 3'h1;
			next_st.rx_ones = ones_next(st.rx_ones, rx_link_bit);
		end
		// A finished byte overwrites the previous one whether read or not.
		if (rx_done)
		begin
			next_st.rx_byte = rx_new_shift;
			set_bits[SR_RX_FULL] = 1'b1;
			if ((rx_new_shift == st.match_one) || (rx_new_shift == st.match_two))
			begin
				set_bits[SR_MATCH] = 1'b1;
			end
		end

		// Transmit: this path owns the slot only when the other source does not.
		legacy_src = esf_mode ? !hdlc_tx_select
			: !first_transmit_control_register[TC_FS_SOURCE];
		tx_stuff = tx_link_req && legacy_src && second_common_control_register[CC_STUFF_EN]
			&& (st.tx_ones == ONES_RUN);
		tx_take = tx_link_req && legacy_src && !tx_stuff;
		tx_load_ok = !second_common_control_register[CC_MF_LOAD] || tx_multiframe;
		// At a byte start the held byte is taken when tx_load_ok allows it; unchanged it simply repeats.
		tx_byte_eff = ((st.tx_count == 3'h0) && tx_load_ok) ? st.tx_hold : st.tx_shift;
		next_st.tx_valid = tx_link_req && legacy_src;
		if (tx_stuff)
		begin
			next_st.tx_bit = 1'b0;
			next_st.tx_ones = 3'h0;
		end
		else if (tx_take)
		begin
			next_st.tx_bit = tx_byte_eff[st.tx_count];
			next_st.tx_shift = tx_byte_eff;
			next_st.tx_count = st.tx_count + 3'h1;
			next_st.tx_ones = ones_next(st.tx_ones, tx_byte_eff[st.tx_count]);
			if (st.tx_count == LAST_BIT)
			begin
				set_bits[SR_TX_EMPTY] = 1'b1;
			end
		end
		else
		begin
			next_st.tx_bit = 1'b0;
		end

		// Register port writes and reads; unmapped reads return zero.
		if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_MATCH_ONE: next_st.match_one = reg_wdata;
				ADDR_MATCH_TWO: next_st.match_two = reg_wdata;
				ADDR_TX_BYTE: next_st.tx_hold = reg_wdata;
				default: next_st.tx_hold = st.tx_hold;
			endcase
		end
		next_st.rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_RX_BYTE: next_st.rdata = st.rx_byte;
				ADDR_MATCH_ONE: next_st.rdata = st.match_one;
				ADDR_MATCH_TWO: next_st.rdata = st.match_two;
				ADDR_TX_BYTE: next_st.rdata = st.tx_hold;
				default: next_st.rdata = 8'h00;
			endcase
		end

		// Sticky status: a set in the same cycle as its clear wins.
		next_st.status = (st.status & ~status_clear) | set_bits;
		next_st.int_n = !(|(next_st.status & second_interrupt_mask_register));
	end

	// State register.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '{rx_shift: BYTE_RESET, rx_count: 3'h0, rx_ones: 3'h0,
				rx_byte: BYTE_RESET, match_one: BYTE_RESET, match_two: BYTE_RESET,
				tx_hold: BYTE_RESET, tx_shift: BYTE_RESET, tx_count: 3'h0,
				tx_ones: 3'h0, tx_valid: 1'b0, tx_bit: 1'b0,
				status: STATUS_RESET, int_n: 1'b1, rdata: 8'h00};
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign reg_rdata = st.rdata;
	assign second_status_register = st.status;
	assign int_n = st.int_n;
	assign tx_link_valid = st.tx_valid;
	assign tx_link_bit = st.tx_bit;

	// Checks next to the logic they guard.
	rx_full_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_done |=> second_status_register[SR_RX_FULL])
		else $error("Receive-full not set after a completed byte.");

	rx_int_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_done && second_interrupt_mask_register[SR_RX_FULL] |=> !int_n)
		else $error("Interrupt not low after masked-in receive-full.");

	match_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_done && ((rx_new_shift == st.match_one) || (rx_new_shift == st.match_two))
		|=> second_status_register[SR_MATCH] && (st.rx_byte == $past(rx_new_shift)))
		else $error("Match flag or byte wrong after a matching byte.");

	rx_last_msb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_done |=> st.rx_byte[7] == $past(rx_link_bit))
		else $error("Last received bit is not in the top position.");

	destuff_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_link_valid && second_common_control_register[CC_DESTUFF_EN]
		&& (st.rx_ones == ONES_RUN) && !rx_link_bit
		|=> $stable(st.rx_count) && $stable(st.rx_shift) && (st.rx_ones == 3'h0))
		else $error("Stuffed zero was not removed.");

	six_ones_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_link_valid && (st.rx_ones > ONES_RUN) && !rx_link_bit
		|=> st.rx_count == $past(st.rx_count) + 3'h1)
		else $error("Zero after six ones was removed.");

	tx_bit_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_take |=> tx_link_valid && (tx_link_bit == $past(tx_byte_eff[st.tx_count])))
		else $error("Transmit bit not taken LSB first.");

	tx_empty_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_take && (st.tx_count == LAST_BIT)
		|=> second_status_register[SR_TX_EMPTY] && (st.tx_count == 3'h0))
		else $error("Transmit-empty not set after eighth bit.");

	tx_int_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_take && (st.tx_count == LAST_BIT) && second_interrupt_mask_register[SR_TX_EMPTY]
		|=> !int_n)
		else $error("Interrupt not low after masked-in transmit-empty.");

	stuff_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_stuff |=> tx_link_valid && !tx_link_bit && $stable(st.tx_count))
		else $error("Zero not stuffed after five ones.");

	one_source_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_link_valid |-> $past(legacy_src) && $past(tx_link_req))
		else $error("Legacy path sent while not the transmit source.");

	mf_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_take && (st.tx_count == 3'h0) && second_common_control_register[CC_MF_LOAD]
		&& !tx_multiframe |=> st.tx_shift == $past(st.tx_shift))
		else $error("Transmit byte loaded off a multiframe boundary.");

	// Register port, status clearing, run counters, byte repeat and transmit source. A stale ones count would
	// silently shift every later stuffing decision, so it is checked on its own.
	rd_rx_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && (reg_addr == ADDR_RX_BYTE) |=> reg_rdata == $past(st.rx_byte))
		else $error("Read of the receive byte returned the wrong value.");

	rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("Read data not zero outside a read.");

	rx_count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!rx_link_valid |=> $stable(st.rx_count))
		else $error("Receive bit count moved without a received bit.");

	rx_full_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		status_clear[SR_RX_FULL] && !rx_done |=> !second_status_register[SR_RX_FULL])
		else $error("Receive-full not cleared by its clear pulse.");

	rx_zero_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rx_link_valid && !rx_link_bit |=> st.rx_ones == 3'h0)
		else $error("Receive ones run not cleared by a zero.");

	tx_zero_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_stuff || (tx_take && !tx_byte_eff[st.tx_count]) |=> st.tx_ones == 3'h0)
		else $error("Transmit ones run not cleared by a zero.");

	tx_repeat_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_take && (st.tx_count == 3'h0) && tx_load_ok |=> st.tx_shift == $past(st.tx_hold))
		else $error("Held transmit byte not taken at a byte start.");

	fs_source_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_link_req && !esf_mode && first_transmit_control_register[TC_FS_SOURCE]
		|=> !tx_link_valid)
		else $error("Fs bit sent while another source owns it.");

	tx_idle_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tx_link_valid |-> !tx_link_bit)
		else $error("Transmit bit not zero outside a served slot.");
endmodule // lbs_shifter

`default_nettype wire

// ==== dv/lbs_framer_model.sv ====
// Framer-side stand-in that feeds received link bits and asks for transmit bits.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lbs_framer_model
(
	input wire logic core_clk,
	output logic rx_link_valid,
	output logic rx_link_bit,
	output logic tx_link_req,
	output logic tx_multiframe
);
	// Strobes idle low from time zero.
	initial
	begin
		rx_link_valid = 1'b0;
		rx_link_bit = 1'b0;
		tx_link_req = 1'b0;
		tx_multiframe = 1'b0;
	end
	// Bits leave from position 0 up; an idle data line shows the inverse of its last bit.
	task automatic send(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge core_clk);
			rx_link_valid = 1'b1;
			rx_link_bit = b[i];
			@(negedge core_clk);
			rx_link_valid = 1'b0;
			rx_link_bit = ~b[i];
		end
	endtask
	// One slot request every other cycle; the boundary flag is only meaningful with it.
	task automatic pull(input int n, input logic mf);
		for (int i = 0; i < n; i++)
		begin
			@(negedge core_clk);
			tx_link_req = 1'b1;
			tx_multiframe = mf;
			@(negedge core_clk);
			tx_link_req = 1'b0;
			tx_multiframe = ~mf;
		end
	endtask
endmodule // lbs_framer_model
`default_nettype wire

// ==== dv/lbs_shifter_tb.sv ====
// Self-checking bench for the legacy link byte shifter.
// Assumes the framer stand-in model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module lbs_shifter_tb;
	import lbs_pkg::*;
	logic core_clk, rst_n, reg_wr, reg_rd, int_n, rd_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ccr, imr, tcr, status_clear, sts, r, d;
	logic esf_mode, hdlc_tx_select, rxv, rxb, txr, txm, tx_link_valid, tx_link_bit;
	logic [7:0] rq[$];
	logic tq[$];
	int err_total, checks_done;
	lbs_shifter lbs_shifter_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.second_common_control_register(ccr), .second_interrupt_mask_register(imr),
		.first_transmit_control_register(tcr), .status_clear(status_clear),
		.second_status_register(sts), .int_n(int_n), .esf_mode(esf_mode),
		.hdlc_tx_select(hdlc_tx_select), .rx_link_valid(rxv), .rx_link_bit(rxb),
		.tx_link_req(txr), .tx_multiframe(txm), .tx_link_valid(tx_link_valid),
		.tx_link_bit(tx_link_bit));
	lbs_framer_model lbs_framer_model_inst (.core_clk(core_clk), .rx_link_valid(rxv),
		.rx_link_bit(rxb), .tx_link_req(txr), .tx_multiframe(txm));
	// Free-running 25 MHz clock.
	always #20 core_clk = ~core_clk;
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask
	// The expected read value is noted first; the watcher compares it later.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
	endtask
	task automatic st(input logic [7:0] e, input logic ei);
		@(negedge core_clk);
		chk8(sts, e);
		chk1(int_n, ei);
	endtask
	// Clearing is a one-cycle pulse, so the status must read back empty.
	task automatic clr();
		@(negedge core_clk);
		status_clear = 8'h1c;
		@(negedge core_clk);
		status_clear = 8'h00;
		st(STATUS_RESET, 1'b1);
	endtask
	task automatic txq(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++)
			tq.push_back(b[i]);
	endtask
	task automatic print_verdict();
		chk8(8'(rq.size() + tq.size()), 8'h00);
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Read data stands one cycle after the strobe; a transmit bit stands with its valid.
	always @(posedge core_clk) rd_q <= reg_rd;
	always @(negedge core_clk)
	begin
		if (rd_q === 1'b1) chk8(reg_rdata, rq.size() ? rq.pop_front() : 8'hxx);
		if (tx_link_valid === 1'b1) chk1(tx_link_bit, tq.size() ? tq.pop_front() : 1'bx);
	end
	// Watchdog sized well above the few hundred cycles the tests need.
	initial
	begin
		#200000;
		err_total++;
		print_verdict();
	end
	// Main sequence; control inputs are swept by hand since the common block is absent.
	initial
	begin
		{core_clk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, err_total, checks_done} = '0;
		{ccr, imr, tcr, status_clear, esf_mode, hdlc_tx_select} = '0;
		esf_mode = 1'b1;
		void'($urandom(4212));
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		st(STATUS_RESET, 1'b1);
		rd(ADDR_TX_BYTE, BYTE_RESET);
		rd(ADDR_MATCH_TWO, BYTE_RESET);
		rd(8'h55, 8'h00);
		$display("reset test done");
		r = {1'b0, 6'($urandom), 1'b0};
		wr(ADDR_MATCH_ONE, r);
		wr(ADDR_MATCH_TWO, 8'hbf);
		imr = 8'h1c;
		lbs_framer_model_inst.send({8'h00, r}, 8);
		st(8'h14, 1'b0);
		rd(ADDR_RX_BYTE, r);
		clr();
		ccr = 8'h01;
		imr = 8'h00;
		lbs_framer_model_inst.send(16'h009f, 9);
		st(8'h10, 1'b1);
		rd(ADDR_RX_BYTE, 8'h5f);
		clr();
		lbs_framer_model_inst.send(16'h00bf, 8);
		st(8'h14, 1'b1);
		wr(ADDR_RX_BYTE, 8'h33);
		rd(ADDR_RX_BYTE, 8'hbf);
		clr();
		$display("receive tests done");
		d = {1'b0, 7'($urandom)};
		imr = 8'h08;
		wr(ADDR_TX_BYTE, d);
		txq({8'h00, d}, 8);
		lbs_framer_model_inst.pull(8, 1'b0);
		st(8'h08, 1'b0);
		clr();
		txq({8'h00, d}, 8);
		lbs_framer_model_inst.pull(8, 1'b0);
		ccr = 8'h10;
		wr(ADDR_TX_BYTE, 8'h1f);
		txq(16'h001f, 9);
		lbs_framer_model_inst.pull(9, 1'b0);
		hdlc_tx_select = 1'b1;
		lbs_framer_model_inst.pull(2, 1'b0);
		hdlc_tx_select = 1'b0;
		{ccr, esf_mode} = {8'h20, 1'b0};
		wr(ADDR_TX_BYTE, 8'h1c);
		txq(16'h1c1f, 16);
		lbs_framer_model_inst.pull(8, 1'b0);
		lbs_framer_model_inst.pull(8, 1'b1);
		tcr = 8'h04;
		lbs_framer_model_inst.pull(2, 1'b0);
		$display("transmit tests done");
		print_verdict();
	end
endmodule // lbs_shifter_tb
`default_nettype wire
